// *** shared/umh_pkg.sv ***
package umh_pkg;

	localparam int PORT_COUNT = 2;
	localparam int MODEM_INPUTS = 4;

	// modem control register fields
	localparam int MCTL_TERM_READY_BIT = 0;
	localparam int MCTL_SEND_REQ_BIT = 1;
	localparam logic [7:0] MCTL_RESET = 8'h00;

	// modem status register layout: change flags low, inverted levels high
	localparam int MSTAT_DELTA_LSB = 0;
	localparam int MSTAT_LEVEL_LSB = 4;
	localparam logic [7:0] MSTAT_RESET = 8'h00;

	// interrupt enable register field
	localparam int IER_MODEM_BIT = 3;

	// handshake input index order inside a port vector
	typedef enum logic [1:0] {
		UMH_IN_CTS,
		UMH_IN_DSR,
		UMH_IN_RI,
		UMH_IN_DCD
	} umh_input_t;

	// pins rest high (inactive) while held in reset
	localparam logic PIN_IDLE = 1'b1;

	// strap sampling after reset release
	localparam logic [1:0] STRAP_CAPTURE_CNT = 2'h1;
	localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2;
	localparam logic STRAP_RESET = 1'b0;
	localparam logic [11:0] INDEX_BASE_LOW = 12'h3F0;
	localparam logic [11:0] INDEX_BASE_HIGH = 12'h370;

endpackage

// *** rtl/umh_sync3.sv ***
`timescale 1ns/1ps
`default_nettype none
module umh_sync3 #(
	parameter int WIDTH = 1,
	parameter logic RST_VAL = 1'b1
) (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] stable_o
);

	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;
	logic [WIDTH-1:0] stable_r;
	logic [WIDTH-1:0] agree;

	// chain is left unreset so it follows the pin during reset
	always_ff @(posedge clock_i) begin
		s1_r <= async_i;
		s2_r <= s1_r;
		s3_r <= s2_r;
	end

	assign agree = s2_r ~^ s3_r;

	// a change counts only once stages two and three agree
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			stable_r <= {WIDTH{RST_VAL}};
		end else begin
			stable_r <= (stable_r & ~agree) | (s3_r & agree);
		end
	end

	assign stable_o = stable_r;

endmodule
`default_nettype wire

// *** rtl/umh_modem_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module umh_modem_ctrl
	import umh_pkg::*;
#(
	parameter logic [11:0] BASE_LOW = INDEX_BASE_LOW,
	parameter logic [11:0] BASE_HIGH = INDEX_BASE_HIGH
) (
	input wire logic clock_i,
	input wire logic rstn_i,

	// port 1 control side
	input wire logic port1_mctl_wr_i,
	input wire logic [7:0] port1_mctl_wdata_i,
	input wire logic port1_loop_mode_i,
	input wire logic [7:0] port1_int_enable_i,
	input wire logic port1_mstat_rd_i,
	output logic [7:0] port1_modem_control_o,
	output logic [7:0] port1_modem_status_o,
	output logic port1_irq_o,

	// port 2 control side
	input wire logic port2_mctl_wr_i,
	input wire logic [7:0] port2_mctl_wdata_i,
	input wire logic port2_loop_mode_i,
	input wire logic [7:0] port2_int_enable_i,
	input wire logic port2_mstat_rd_i,
	output logic [7:0] port2_modem_control_o,
	output logic [7:0] port2_modem_status_o,
	output logic port2_irq_o,

	// port 1 modem pins
	input wire logic port1_clear_to_send_n_i,
	input wire logic port1_set_ready_n_i,
	input wire logic port1_carrier_detect_n_i,
	input wire logic port1_ring_n_i,
	output logic port1_send_request_n_o,
	output logic port1_terminal_ready_n_o,

	// port 2 modem pins; send-request doubles as strap input
	input wire logic port2_clear_to_send_n_i,
	input wire logic port2_set_ready_n_i,
	input wire logic port2_carrier_detect_n_i,
	input wire logic port2_ring_n_i,
	input wire logic port2_send_request_n_i,
	output logic port2_send_request_n_o,
	output logic port2_send_request_oe_o,
	output logic port2_terminal_ready_n_o,

	// configuration strap result
	output logic config_base_strap_o,
	output logic [11:0] config_index_base_o
);

	logic [MODEM_INPUTS-1:0] pin_n [PORT_COUNT];
	logic [MODEM_INPUTS-1:0] level_n [PORT_COUNT];
	logic [MODEM_INPUTS-1:0] prev_n_r [PORT_COUNT];
	logic [MODEM_INPUTS-1:0] rise [PORT_COUNT];
	logic [MODEM_INPUTS-1:0] chg [PORT_COUNT];
	logic mctl_wr [PORT_COUNT];
	logic [7:0] mctl_wdata [PORT_COUNT];
	logic loop_mode [PORT_COUNT];
	logic [7:0] int_enable [PORT_COUNT];
	logic mstat_rd [PORT_COUNT];
	logic [7:0] mctl_r [PORT_COUNT];
	logic [7:0] mstat_r [PORT_COUNT];
	logic chg_any_r [PORT_COUNT];
	logic send_n_r [PORT_COUNT];
	logic term_n_r [PORT_COUNT];
	logic irq [PORT_COUNT];

	logic [1:0] settle_cnt_r;
	logic settled;
	logic strap_level;
	logic strap_r;
	logic [11:0] index_base_r;

	// gather per-port signals into arrays
	assign pin_n[0] = {port1_carrier_detect_n_i, port1_ring_n_i, port1_set_ready_n_i, port1_clear_to_send_n_i};
	assign pin_n[1] = {port2_carrier_detect_n_i, port2_ring_n_i, port2_set_ready_n_i, port2_clear_to_send_n_i};
	assign mctl_wr[0] = port1_mctl_wr_i;
	assign mctl_wr[1] = port2_mctl_wr_i;
	assign mctl_wdata[0] = port1_mctl_wdata_i;
	assign mctl_wdata[1] = port2_mctl_wdata_i;
	assign loop_mode[0] = port1_loop_mode_i;
	assign loop_mode[1] = port2_loop_mode_i;
	assign int_enable[0] = port1_int_enable_i;
	assign int_enable[1] = port2_int_enable_i;
	assign mstat_rd[0] = port1_mstat_rd_i;
	assign mstat_rd[1] = port2_mstat_rd_i;

	// post-reset window: inputs settle, strap is sampled
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			settle_cnt_r <= 2'h0;
		end else if (!settled) begin
			settle_cnt_r <= settle_cnt_r + 2'h1;
		end
	end

	assign settled = (settle_cnt_r == STRAP_SETTLE_CYCLES);

	genvar p;
	generate
		for (p = 0; p < PORT_COUNT; p++) begin : g_port

			umh_sync3 #(
				.WIDTH(MODEM_INPUTS),
				.RST_VAL(PIN_IDLE)
			) u_sync (
				.clock_i(clock_i),
				.rstn_i(rstn_i),
				.async_i(pin_n[p]),
				.stable_o(level_n[p])
			);

			// modem control register
			always_ff @(posedge clock_i) begin
				if (!rstn_i) begin
					mctl_r[p] <= MCTL_RESET;
				end else if (mctl_wr[p]) begin
					mctl_r[p] <= mctl_wdata[p];
				end
			end

			// handshake outputs, forced inactive in reset and loop mode
			always_ff @(posedge clock_i) begin
				if (!rstn_i) begin
					send_n_r[p] <= PIN_IDLE;
					term_n_r[p] <= PIN_IDLE;
				end else begin
					send_n_r[p] <= loop_mode[p] | ~mctl_r[p][MCTL_SEND_REQ_BIT];
					term_n_r[p] <= loop_mode[p] | ~mctl_r[p][MCTL_TERM_READY_BIT];
				end
			end

			// edge detection on settled pin levels
			always_ff @(posedge clock_i) begin
				if (!rstn_i) begin
					prev_n_r[p] <= {MODEM_INPUTS{PIN_IDLE}};
				end else begin
					prev_n_r[p] <= level_n[p];
				end
			end

			assign rise[p] = settled ? (level_n[p] & ~prev_n_r[p]) : '0;
			assign chg[p] = settled ? (level_n[p] ^ prev_n_r[p]) : '0;

			// status: inverted levels high, sticky rising flags low; set beats read clear
			always_ff @(posedge clock_i) begin
				if (!rstn_i) begin
					mstat_r[p] <= MSTAT_RESET;
				end else begin
					mstat_r[p][MSTAT_LEVEL_LSB +: MODEM_INPUTS] <= ~level_n[p];
					if (mstat_rd[p]) begin
						mstat_r[p][MSTAT_DELTA_LSB +: MODEM_INPUTS] <= rise[p];
					end else begin
						mstat_r[p][MSTAT_DELTA_LSB +: MODEM_INPUTS] <=
							mstat_r[p][MSTAT_DELTA_LSB +: MODEM_INPUTS] | rise[p];
					end
				end
			end

			// any change of state is remembered until the status read
			always_ff @(posedge clock_i) begin
				if (!rstn_i) begin
					chg_any_r[p] <= 1'b0;
				end else if (|chg[p]) begin
					chg_any_r[p] <= 1'b1;
				end else if (mstat_rd[p]) begin
					chg_any_r[p] <= 1'b0;
				end
			end

			// clear-to-send feeds only status and interrupt, no transmit gating
			assign irq[p] = int_enable[p][IER_MODEM_BIT] & chg_any_r[p];

			// checks
			property p_send_drive;
				@(posedge clock_i) disable iff (!rstn_i)
				(!loop_mode[p] && mctl_r[p][MCTL_SEND_REQ_BIT]) |=> !send_n_r[p];
			endproperty
			a_send_drive: assert property (p_send_drive) else $error("send-request not driven low");

			property p_send_idle;
				@(posedge clock_i) disable iff (!rstn_i)
				(loop_mode[p] || !mctl_r[p][MCTL_SEND_REQ_BIT]) |=> send_n_r[p];
			endproperty
			a_send_idle: assert property (p_send_idle) else $error("send-request low while not requested");

			property p_ctrl_store;
				@(posedge clock_i) disable iff (!rstn_i)
				mctl_wr[p] |=> mctl_r[p] == $past(mctl_wdata[p]);
			endproperty
			a_ctrl_store: assert property (p_ctrl_store) else $error("control byte not stored");

			property p_term_drive;
				@(posedge clock_i) disable iff (!rstn_i)
				(!loop_mode[p] && mctl_r[p][MCTL_TERM_READY_BIT]) |=> !term_n_r[p];
			endproperty
			a_term_drive: assert property (p_term_drive) else $error("terminal-ready not driven low");

			property p_send_reset;
				@(posedge clock_i) disable iff (!rstn_i)
				$rose(rstn_i) |-> send_n_r[p];
			endproperty
			a_send_reset: assert property (p_send_reset) else $error("send-request low out of reset");

			property p_term_reset;
				@(posedge clock_i) disable iff (!rstn_i)
				$rose(rstn_i) |-> term_n_r[p];
			endproperty
			a_term_reset: assert property (p_term_reset) else $error("terminal-ready low out of reset");

			property p_send_loop;
				@(posedge clock_i) disable iff (!rstn_i)
				loop_mode[p] |=> send_n_r[p];
			endproperty
			a_send_loop: assert property (p_send_loop) else $error("send-request active in loop mode");

			property p_term_loop;
				@(posedge clock_i) disable iff (!rstn_i)
				(loop_mode[p] && mctl_r[p][MCTL_TERM_READY_BIT]) |=> term_n_r[p];
			endproperty
			a_term_loop: assert property (p_term_loop) else $error("terminal-ready active in loop mode");

			property p_level_mirror;
				@(posedge clock_i) disable iff (!rstn_i)
				##1 1'b1 |-> mstat_r[p][MSTAT_LEVEL_LSB +: MODEM_INPUTS] == ~$past(level_n[p]);
			endproperty
			a_level_mirror: assert property (p_level_mirror) else $error("status level bits wrong");

			property p_rise_flag;
				@(posedge clock_i) disable iff (!rstn_i)
				(|rise[p]) |=> ((mstat_r[p][MSTAT_DELTA_LSB +: MODEM_INPUTS] & $past(rise[p])) == $past(rise[p]));
			endproperty
			a_rise_flag: assert property (p_rise_flag) else $error("change flag missed");

			property p_read_clear;
				@(posedge clock_i) disable iff (!rstn_i)
				(mstat_rd[p] && !(|rise[p])) |=> mstat_r[p][MSTAT_DELTA_LSB +: MODEM_INPUTS] == '0;
			endproperty
			a_read_clear: assert property (p_read_clear) else $error("change flags not cleared by read");

			property p_flag_hold;
				@(posedge clock_i) disable iff (!rstn_i)
				(!mstat_rd[p] && (|mstat_r[p][MSTAT_DELTA_LSB +: MODEM_INPUTS])) |=>
					(|mstat_r[p][MSTAT_DELTA_LSB +: MODEM_INPUTS]);
			endproperty
			a_flag_hold: assert property (p_flag_hold) else $error("change flag lost without read");

			property p_irq_raise;
				@(posedge clock_i) disable iff (!rstn_i)
				(|chg[p]) ##1 int_enable[p][IER_MODEM_BIT] |-> irq[p];
			endproperty
			a_irq_raise: assert property (p_irq_raise) else $error("modem interrupt not raised");

			property p_chg_pending;
				@(posedge clock_i) disable iff (!rstn_i)
				(|chg[p]) |=> chg_any_r[p];
			endproperty
			a_chg_pending: assert property (p_chg_pending) else $error("pin change not held pending");

			property p_irq_clear;
				@(posedge clock_i) disable iff (!rstn_i)
				(mstat_rd[p] && !(|chg[p])) |=> !irq[p];
			endproperty
			a_irq_clear: assert property (p_irq_clear) else $error("modem interrupt kept after status read");

			property p_irq_gate;
				@(posedge clock_i) disable iff (!rstn_i)
				!int_enable[p][IER_MODEM_BIT] |-> !irq[p];
			endproperty
			a_irq_gate: assert property (p_irq_gate) else $error("modem interrupt while disabled");

			property p_no_early_edge;
				@(posedge clock_i) disable iff (!rstn_i)
				$rose(rstn_i) |-> (chg[p] == '0) ##1 (chg[p] == '0);
			endproperty
			a_no_early_edge: assert property (p_no_early_edge) else $error("edge seen before settle");

		end
	endgenerate

	// strap on the second send-request pin, sampled after reset release
	umh_sync3 #(
		.WIDTH(1),
		.RST_VAL(STRAP_RESET)
	) u_strap_sync (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.async_i(port2_send_request_n_i),
		.stable_o(strap_level)
	);

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			strap_r <= STRAP_RESET;
		end else if (settle_cnt_r == STRAP_CAPTURE_CNT) begin
			strap_r <= strap_level;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			index_base_r <= BASE_LOW;
		end else begin
			index_base_r <= strap_r ? BASE_HIGH : BASE_LOW;
		end
	end

	property p_strap_capture;
		@(posedge clock_i) disable iff (!rstn_i)
		(settle_cnt_r == STRAP_CAPTURE_CNT) |=> strap_r == $past(strap_level) ##1
			index_base_r == (strap_r ? BASE_HIGH : BASE_LOW);
	endproperty
	a_strap_capture: assert property (p_strap_capture) else $error("strap not captured");

	property p_strap_stable;
		@(posedge clock_i) disable iff (!rstn_i)
		settled |=> $stable(strap_r);
	endproperty
	a_strap_stable: assert property (p_strap_stable) else $error("strap changed after sampling");

	property p_strap_release;
		@(posedge clock_i) disable iff (!rstn_i)
		$rose(rstn_i) |-> !port2_send_request_oe_o [*2] ##1 port2_send_request_oe_o;
	endproperty
	a_strap_release: assert property (p_strap_release) else $error("strap pin driven too early");

	// outputs
	assign port1_modem_control_o = mctl_r[0];
	assign port2_modem_control_o = mctl_r[1];
	assign port1_modem_status_o = mstat_r[0];
	assign port2_modem_status_o = mstat_r[1];
	assign port1_irq_o = irq[0];
	assign port2_irq_o = irq[1];
	assign port1_send_request_n_o = send_n_r[0];
	assign port1_terminal_ready_n_o = term_n_r[0];
	assign port2_send_request_n_o = send_n_r[1];
	assign port2_terminal_ready_n_o = term_n_r[1];
	// pin released while the strap is read
	assign port2_send_request_oe_o = rstn_i & settled;
	assign config_base_strap_o = strap_r;
	assign config_index_base_o = index_base_r;

endmodule
`default_nettype wire

// *** verif/umh_modem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module umh_modem_model (
	input wire logic req2_n_i,
	input wire logic req2_oe_i,
	output logic [3:0] port1_pins_n_o,
	output logic [3:0] port2_pins_n_o,
	output logic req2_line_o
);
	logic strap_pull_r;
	initial begin
		port1_pins_n_o = 4'hF;
		port2_pins_n_o = 4'hF;
		strap_pull_r = 1'b1;
	end
	// handshake pins change with no relation to the clock
	task automatic set_pin(input int p, input int i, input logic v);
		if (p == 0) begin
			port1_pins_n_o[i] = v;
		end else begin
			port2_pins_n_o[i] = v;
		end
	endtask
	task automatic set_pull(input logic v);
		strap_pull_r = v;
	endtask
	// released pin falls back to the board strap level
	assign req2_line_o = req2_oe_i ? req2_n_i : strap_pull_r;
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_top;
	import umh_pkg::*;
	logic clock_i = 1'b0;
	logic rstn_i = 1'b0;
	logic ctl_wr [2] = '{1'b0, 1'b0};
	logic [7:0] ctl_wdata [2] = '{8'h00, 8'h00};
	logic loop_mode [2] = '{1'b0, 1'b0};
	logic [7:0] int_en [2] = '{8'h00, 8'h00};
	logic stat_rd [2] = '{1'b0, 1'b0};
	wire [7:0] ctrl [2];
	wire [7:0] status [2];
	wire irq [2];
	wire req_n [2];
	wire term_n [2];
	wire [3:0] pins1;
	wire [3:0] pins2;
	wire req2_line;
	wire req2_oe;
	wire strap;
	wire [11:0] base;
	int bad_count = 0;
	int checked = 0;
	int cycles = 0;
	logic [7:0] v;
	always #2 clock_i = ~clock_i;
	umh_modem_model u_modem (.req2_n_i(req_n[1]), .req2_oe_i(req2_oe), .port1_pins_n_o(pins1),
		.port2_pins_n_o(pins2), .req2_line_o(req2_line));
	umh_modem_ctrl uut (.clock_i(clock_i), .rstn_i(rstn_i),
		.port1_mctl_wr_i(ctl_wr[0]), .port1_mctl_wdata_i(ctl_wdata[0]), .port1_loop_mode_i(loop_mode[0]),
		.port1_int_enable_i(int_en[0]), .port1_mstat_rd_i(stat_rd[0]), .port1_modem_control_o(ctrl[0]),
		.port1_modem_status_o(status[0]), .port1_irq_o(irq[0]),
		.port2_mctl_wr_i(ctl_wr[1]), .port2_mctl_wdata_i(ctl_wdata[1]), .port2_loop_mode_i(loop_mode[1]),
		.port2_int_enable_i(int_en[1]), .port2_mstat_rd_i(stat_rd[1]), .port2_modem_control_o(ctrl[1]),
		.port2_modem_status_o(status[1]), .port2_irq_o(irq[1]),
		.port1_clear_to_send_n_i(pins1[0]), .port1_set_ready_n_i(pins1[1]), .port1_ring_n_i(pins1[2]),
		.port1_carrier_detect_n_i(pins1[3]), .port1_send_request_n_o(req_n[0]),
		.port1_terminal_ready_n_o(term_n[0]),
		.port2_clear_to_send_n_i(pins2[0]), .port2_set_ready_n_i(pins2[1]), .port2_ring_n_i(pins2[2]),
		.port2_carrier_detect_n_i(pins2[3]), .port2_send_request_n_i(req2_line),
		.port2_send_request_n_o(req_n[1]), .port2_send_request_oe_o(req2_oe),
		.port2_terminal_ready_n_o(term_n[1]), .config_base_strap_o(strap), .config_index_base_o(base));
	task automatic tick();
		@(posedge clock_i);
		#1;
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			end_sim();
		end
	end
	task automatic wr_ctl(input int p, input logic [7:0] d);
		ctl_wr[p] = 1'b1;
		ctl_wdata[p] = d;
		tick();
		ctl_wr[p] = 1'b0;
	endtask
	// status is a register, so the value seen before the strobe edge is the read value
	task automatic rd_stat(input int p, output logic [7:0] d);
		stat_rd[p] = 1'b1;
		d = status[p];
		tick();
		stat_rd[p] = 1'b0;
	endtask
	task automatic wait_stat(input int p, input logic [7:0] e);
		int n = 0;
		while (status[p] !== e && n < 16) begin
			tick();
			n++;
		end
		`CHECK("status", e, status[p])
	endtask
	task automatic do_reset(input logic pull);
		u_modem.set_pull(pull);
		rstn_i = 1'b0;
		repeat (6) tick();
		`CHECK("oe_rst", 1'b0, req2_oe)
		for (int p = 0; p < 2; p++) begin
			`CHECK("req_rst", PIN_IDLE, req_n[p])
			`CHECK("term_rst", PIN_IDLE, term_n[p])
			`CHECK("status_rst", MSTAT_RESET, status[p])
		end
		rstn_i = 1'b1;
		repeat (4) tick();
		`CHECK("strap", pull, strap)
		`CHECK("base", pull ? INDEX_BASE_HIGH : INDEX_BASE_LOW, base)
		`CHECK("oe_run", 1'b1, req2_oe)
		`CHECK("ctrl_rst", MCTL_RESET, ctrl[0])
		`CHECK("req_idle", PIN_IDLE, req_n[1])
		$display("test reset strap %0d done", pull);
	endtask
	initial begin
		do_reset(1'b1);
		for (int p = 0; p < 2; p++) begin
			for (int k = 0; k < 4; k++) begin
				wr_ctl(p, 8'(k));
				`CHECK("ctrl", 8'(k), ctrl[p])
				repeat (2) tick();
				`CHECK("req", ~k[1], req_n[p])
				`CHECK("term", ~k[0], term_n[p])
			end
			loop_mode[p] = 1'b1;
			repeat (2) tick();
			`CHECK("req_loop", 1'b1, req_n[p])
			`CHECK("term_loop", 1'b1, term_n[p])
			`CHECK("ctrl_loop", 8'h03, ctrl[p])
			loop_mode[p] = 1'b0;
			repeat (2) tick();
			`CHECK("req_unloop", 1'b0, req_n[p])
		end
		$display("test control done");
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 4; i++) begin
				int_en[p] = 8'h08;
				u_modem.set_pin(p, i, 1'b0);
				wait_stat(p, 8'h10 << i);
				`CHECK("irq_fall", 1'b1, irq[p])
				rd_stat(p, v);
				`CHECK("irq_clr", 1'b0, irq[p])
				int_en[p] = 8'h00;
				u_modem.set_pin(p, i, 1'b1);
				wait_stat(p, 8'h01 << i);
				`CHECK("irq_mask", 1'b0, irq[p])
				int_en[p] = 8'h08;
				tick();
				`CHECK("irq_unmask", 1'b1, irq[p])
				`CHECK("req_cts", 1'b0, req_n[p])
				rd_stat(p, v);
				`CHECK("rd_val", 8'h01 << i, v)
				`CHECK("flags_clr", 8'h00, status[p])
				`CHECK("irq_rd", 1'b0, irq[p])
			end
		end
		$display("test status done");
		u_modem.set_pin(0, 0, 1'b0);
		do_reset(1'b0);
		`CHECK("held_level", 8'h10, status[0])
		`CHECK("held_irq", 1'b0, irq[0])
		u_modem.set_pin(0, 0, 1'b1);
		wait_stat(0, 8'h01);
		`CHECK("held_rise_irq", 1'b1, irq[0])
		$display("test reset with pin held done");
		end_sim();
	end
endmodule
`default_nettype wire
